// >>> logic/usu_serial_unit.sv
// Overview of operation
// R01: a software write to the shift register beats a same-cycle shift clock
// R02: shift left on the clock picked by clock select: pin edge, timer, strobe
// R03: data and clock pins feed the shift register even with no wire mode
// R04: serial output pin driven from shift register bit 7 via output latch
// R05: latch open first half of cycle with external clock, always if internal
// R06: a new top bit passes the open latch to the pin at once
// R07: on transfer completion the shift register is copied to the receive buffer
// R08: start flag set by start condition, or any clock pin edge in other modes when clock select is soft
// R09: start interrupt while start flag, its enable and global enable are set
// R10: start flag cleared by writing one, which releases the clock hold
// R11: start interrupt wakes the processor from every sleep mode
// R12: overflow flag set when the counter wraps from fifteen to zero
// R13: overflow interrupt while overflow flag, its enable and global enable set
// R14: overflow flag cleared by writing one, which releases the clock hold
// R15: overflow interrupt wakes the processor from idle sleep
// R16: stop flag set by stop condition, cleared by writing one, no interrupt
// R17: collision bit reads one when bit 7 differs from the data line level
// R18: counter readable and writable in the low four status bits
// R19: counter steps once per selected clock: pin edge, timer, strobes; with external clock the code counts both pin edges
// R20: with external clock and soft strobe written, toggle makes the clock
// R21: clock pin feeds the counter even with no wire mode
// R22: software sets the pin direction to output before data can leave
// R23: soft clock and toggle strobes are one-cycle pulses, read as zero
`timescale 1ns/10ps
module usu_serial_unit (
	input wire logic core_clk, // 200 MHz system clock
	input wire logic arst_n, // async reset, active low
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire logic pwrite, // apb direction
	input wire logic [11:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error on unmapped address
	input wire logic globalIrqEnable, // cpu global interrupt enable
	input wire logic timerMatch, // timer 0 compare match pulse
	input wire logic dataOutDir, // direction bit of data out pin
	input wire logic clockPinDir, // direction bit of clock pin
	input wire logic dataLineDir, // direction bit of two-wire data line
	input wire logic serialDataIn, // three-wire data in pin
	output logic serialDataOut, // three-wire data out pin
	output logic serialDataOutOe, // three-wire data out enable
	input wire logic serialClockPinIn, // clock pin level
	output logic serialClockPinOut, // clock pin drive value
	output logic serialClockPinOe, // clock pin drive enable
	input wire logic dataLineIn, // two-wire data line level
	output logic dataLineOut, // two-wire data line drive value
	output logic dataLineOe, // two-wire data line drive enable
	output logic startIrq, // start condition interrupt request
	output logic overflowIrq, // counter overflow interrupt request
	output logic wakeAnySleep, // wake request valid in all sleep modes
	output logic wakeIdle // wake request valid in idle only
);
	typedef struct packed {
		logic [7:0] shiftReg;
		logic [7:0] rxBuf;
		logic [3:0] count;
		logic startFlag;
		logic ovfFlag;
		logic stopFlag;
		logic sie;
		logic oie;
		logic [1:0] wm;
		logic [1:0] cs;
		logic clkOut;
		logic outLatch;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic startIrq;
		logic ovfIrq;
		logic doOut;
		logic doOe;
		logic sclOut;
		logic sclOe;
		logic sdaOe;
	} usu_state_t;

	usu_state_t st;
	usu_state_t next_st;

	usu_pin_if diIf();
	usu_pin_if sclIf();
	usu_pin_if sdaIf();

	assign diIf.pin = serialDataIn;
	assign sclIf.pin = serialClockPinIn;
	assign sdaIf.pin = dataLineIn;

	usu_pin_sync u_di_sync (.core_clk(core_clk), .arst_n(arst_n), .pinIf(diIf)); // R03
	usu_pin_sync u_scl_sync (.core_clk(core_clk), .arst_n(arst_n), .pinIf(sclIf)); // R21
	usu_pin_sync u_sda_sync (.core_clk(core_clk), .arst_n(arst_n), .pinIf(sdaIf));

	logic wrStb;
	logic rdSetup;
	logic wrShift;
	logic wrStatus;
	logic wrControl;
	logic twoWire;
	logic extClk;
	logic softStb;
	logic toggleStb;
	logic shiftTick;
	logic countTick;
	logic dataBit;
	logic collision;
	logic startEvent;
	logic stopEvent;
	logic ovfEvent;
	logic latchOpen;
	logic holdActive;
	logic mapped;

	always_comb
	begin
		wrStb = psel & penable & st.pready & pwrite;
		rdSetup = psel & ~penable;
		mapped = (paddr == usu_pkg::ADDR_SHIFT) || (paddr == usu_pkg::ADDR_BUFFER) ||
			(paddr == usu_pkg::ADDR_STATUS) || (paddr == usu_pkg::ADDR_CONTROL);
		wrShift = wrStb & (paddr == usu_pkg::ADDR_SHIFT);
		wrStatus = wrStb & (paddr == usu_pkg::ADDR_STATUS);
		wrControl = wrStb & (paddr == usu_pkg::ADDR_CONTROL);
		twoWire = st.wm[1];
		extClk = st.cs[1];
		// strobes live only in the write cycle, nothing stores them
		softStb = wrControl & pwdata[usu_pkg::CT_SOFTCLK]; // R23
		toggleStb = wrControl & pwdata[usu_pkg::CT_TOGGLE]; // R23
		dataBit = twoWire ? sdaIf.level : diIf.level;
		unique case (usu_pkg::usu_clksel_t'(st.cs))
			usu_pkg::CS_SOFT: shiftTick = softStb; // R02
			usu_pkg::CS_TIMER: shiftTick = timerMatch; // R02
			usu_pkg::CS_EXT_RISE: shiftTick = sclIf.rise; // R02
			usu_pkg::CS_EXT_FALL: shiftTick = sclIf.fall; // R02
		endcase
		// external mode counts both pin edges, so a toggled pin counts too
		countTick = extClk ? (sclIf.rise | sclIf.fall) : shiftTick; // R19
		collision = st.shiftReg[7] ^ sdaIf.level; // R17
		startEvent = twoWire ? (sdaIf.fall & sclIf.level) : // R08
			((st.cs == 2'h0) & (sclIf.rise | sclIf.fall)); // R08
		stopEvent = twoWire & sdaIf.rise & sclIf.level; // R16
		ovfEvent = countTick & (st.count == usu_pkg::CNT_MAX) & ~wrStatus; // R12
		// first half of the serial cycle is the half before the sampling edge
		latchOpen = ~extClk | (st.cs[0] ? sclIf.level : ~sclIf.level); // R05
		holdActive = twoWire & (st.startFlag | (st.wm[0] & st.ovfFlag)); // R10 R14

		next_st = st;
		// shift register
		if (wrShift)
			next_st.shiftReg = pwdata[7:0]; // R01
		else if (shiftTick)
			next_st.shiftReg = {st.shiftReg[6:0], dataBit}; // R02 R03
		// counter
		if (wrStatus)
			next_st.count = pwdata[usu_pkg::ST_CNT_LO +: 4]; // R18
		else if (countTick)
			next_st.count = st.count + usu_pkg::CNT_STEP; // R19 R21
		if (ovfEvent)
			next_st.rxBuf = next_st.shiftReg; // R07
		// flags: set beats the write-one clear
		next_st.startFlag = startEvent | (st.startFlag & ~(wrStatus & pwdata[usu_pkg::ST_START])); // R08 R10
		next_st.ovfFlag = ovfEvent | (st.ovfFlag & ~(wrStatus & pwdata[usu_pkg::ST_OVF])); // R12 R14
		next_st.stopFlag = stopEvent | (st.stopFlag & ~(wrStatus & pwdata[usu_pkg::ST_STOP])); // R16
		if (wrControl)
		begin
			next_st.sie = pwdata[usu_pkg::CT_SIE];
			next_st.oie = pwdata[usu_pkg::CT_OIE];
			next_st.wm = pwdata[usu_pkg::CT_WM_LO +: 2];
			next_st.cs = pwdata[usu_pkg::CT_CS_LO +: 2];
		end
		// external clock needs the soft strobe written with the toggle
		if (toggleStb & (~extClk | softStb))
			next_st.clkOut = ~st.clkOut; // R20
		if (latchOpen)
			next_st.outLatch = next_st.shiftReg[7]; // R04 R06
		// apb: answer in the access cycle right after setup
		next_st.pready = rdSetup;
		next_st.pslverr = rdSetup & ~mapped;
		next_st.prdata = '0;
		if (rdSetup)
		begin
			unique case (paddr)
				usu_pkg::ADDR_SHIFT: next_st.prdata[7:0] = st.shiftReg;
				usu_pkg::ADDR_BUFFER: next_st.prdata[7:0] = st.rxBuf; // R07
				usu_pkg::ADDR_STATUS: next_st.prdata[7:0] = {st.startFlag, st.ovfFlag, st.stopFlag,
					collision, st.count}; // R17 R18
				usu_pkg::ADDR_CONTROL: next_st.prdata[7:0] = {st.sie, st.oie, st.wm, st.cs, 2'h0}; // R23
				default: next_st.prdata = '0;
			endcase
		end
		next_st.startIrq = st.startFlag & st.sie & globalIrqEnable; // R09
		next_st.ovfIrq = st.ovfFlag & st.oie & globalIrqEnable; // R13
		// pins: software sets the direction bits first
		// pins follow the latch input: a flop less keeps a bit inside half a serial period
		next_st.doOut = next_st.outLatch; // R04 R06
		next_st.doOe = dataOutDir & (st.wm == 2'h1); // R22
		// two-wire lines are open drain: only ever pull low
		next_st.sdaOe = dataLineDir & twoWire & ~next_st.outLatch; // R04 R22
		next_st.sclOut = twoWire ? 1'b0 : st.clkOut;
		next_st.sclOe = clockPinDir & (twoWire ? (holdActive | ~st.clkOut) : 1'b1); // R10 R14
	end

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			st <= '0;
			st.shiftReg <= usu_pkg::SHIFT_RESET;
			st.count <= usu_pkg::STATUS_RESET[3:0];
		end
		else
			st <= next_st;
	end

	assign prdata = st.prdata;
	assign pready = st.pready;
	assign pslverr = st.pslverr;
	assign serialDataOut = st.doOut;
	assign serialDataOutOe = st.doOe;
	assign serialClockPinOut = st.sclOut;
	assign serialClockPinOe = st.sclOe;
	assign dataLineOut = 1'b0;
	assign dataLineOe = st.sdaOe;
	assign startIrq = st.startIrq;
	assign overflowIrq = st.ovfIrq;
	assign wakeAnySleep = st.startIrq; // R11
	assign wakeIdle = st.ovfIrq; // R15

	sequence s_shift_write;
		wrShift;
	endsequence

	sequence s_wrap;
		countTick && (st.count == usu_pkg::CNT_MAX) && !wrStatus;
	endsequence

	property p_write_wins;
		@(posedge core_clk) disable iff (!arst_n)
		s_shift_write |=> st.shiftReg == $past(pwdata[7:0]);
	endproperty
	a_write_wins: assert property (p_write_wins) else $error("shift write lost"); // R01

	property p_shift_left;
		@(posedge core_clk) disable iff (!arst_n)
		shiftTick && !wrShift |=> st.shiftReg == {$past(st.shiftReg[6:0]), $past(dataBit)};
	endproperty
	a_shift_left: assert property (p_shift_left) else $error("shift wrong"); // R02

	property p_latch_closed;
		@(posedge core_clk) disable iff (!arst_n)
		!latchOpen |=> $stable(st.outLatch) && serialDataOut == st.outLatch;
	endproperty
	a_latch_closed: assert property (p_latch_closed) else $error("latch not held"); // R05

	property p_latch_open;
		@(posedge core_clk) disable iff (!arst_n)
		!extClk && !wrControl ##0 s_shift_write |=> serialDataOut == $past(pwdata[7]);
	endproperty
	a_latch_open: assert property (p_latch_open) else $error("msb not on pin"); // R06

	property p_buffer_load;
		@(posedge core_clk) disable iff (!arst_n)
		s_wrap |=> st.rxBuf == st.shiftReg && st.ovfFlag && st.count == 4'h0;
	endproperty
	a_buffer_load: assert property (p_buffer_load) else $error("wrap effects missing"); // R07 R12

	property p_start_set;
		@(posedge core_clk) disable iff (!arst_n)
		startEvent |=> st.startFlag;
	endproperty
	a_start_set: assert property (p_start_set) else $error("start flag missed"); // R08

	property p_start_irq;
		@(posedge core_clk) disable iff (!arst_n)
		st.startFlag && st.sie && globalIrqEnable |=> startIrq && wakeAnySleep;
	endproperty
	a_start_irq: assert property (p_start_irq) else $error("start irq missing"); // R09 R11

	property p_start_clear;
		@(posedge core_clk) disable iff (!arst_n)
		wrStatus && pwdata[usu_pkg::ST_START] && !startEvent |=> !st.startFlag;
	endproperty
	a_start_clear: assert property (p_start_clear) else $error("start not cleared"); // R10

	property p_ovf_irq;
		@(posedge core_clk) disable iff (!arst_n)
		!st.ovfFlag |=> !overflowIrq;
	endproperty
	a_ovf_irq: assert property (p_ovf_irq) else $error("overflow irq without flag"); // R13

	property p_stop_sticky;
		@(posedge core_clk) disable iff (!arst_n)
		st.stopFlag && !wrStatus |=> st.stopFlag;
	endproperty
	a_stop_sticky: assert property (p_stop_sticky) else $error("stop flag dropped"); // R16

	property p_count_write;
		@(posedge core_clk) disable iff (!arst_n)
		wrStatus |=> st.count == $past(pwdata[3:0]);
	endproperty
	a_count_write: assert property (p_count_write) else $error("count write lost"); // R18

	property p_stop_set;
		@(posedge core_clk) disable iff (!arst_n)
		stopEvent |=> st.stopFlag;
	endproperty
	a_stop_set: assert property (p_stop_set) else $error("stop flag missed"); // R16

	property p_ovf_clear;
		@(posedge core_clk) disable iff (!arst_n)
		wrStatus && pwdata[usu_pkg::ST_OVF] && !ovfEvent |=> !st.ovfFlag;
	endproperty
	a_ovf_clear: assert property (p_ovf_clear) else $error("overflow not cleared"); // R14

	property p_count_step;
		@(posedge core_clk) disable iff (!arst_n)
		countTick && !wrStatus |=> st.count == $past(st.count) + usu_pkg::CNT_STEP;
	endproperty
	a_count_step: assert property (p_count_step) else $error("count step wrong"); // R19

	property p_collision_read;
		@(posedge core_clk) disable iff (!arst_n)
		rdSetup && paddr == usu_pkg::ADDR_STATUS |=>
			prdata[usu_pkg::ST_COLL] == ($past(st.shiftReg[7]) ^ $past(sdaIf.level));
	endproperty
	a_collision_read: assert property (p_collision_read) else $error("collision bit wrong"); // R17

	property p_strobe_read;
		@(posedge core_clk) disable iff (!arst_n)
		rdSetup && paddr == usu_pkg::ADDR_CONTROL |=> prdata[1:0] == 2'h0;
	endproperty
	a_strobe_read: assert property (p_strobe_read) else $error("strobe bits read back"); // R23

	property p_toggle_gate;
		@(posedge core_clk) disable iff (!arst_n)
		toggleStb && extClk && !softStb |=> $stable(st.clkOut);
	endproperty
	a_toggle_gate: assert property (p_toggle_gate) else $error("toggle without soft strobe"); // R20

	property p_toggle_flip;
		@(posedge core_clk) disable iff (!arst_n)
		toggleStb && (!extClk || softStb) |=> st.clkOut != $past(st.clkOut);
	endproperty
	a_toggle_flip: assert property (p_toggle_flip) else $error("toggle lost"); // R20

	property p_ovf_irq_set;
		@(posedge core_clk) disable iff (!arst_n)
		st.ovfFlag && st.oie && globalIrqEnable |=> overflowIrq && wakeIdle;
	endproperty
	a_ovf_irq_set: assert property (p_ovf_irq_set) else $error("overflow irq missing"); // R13 R15

	property p_clock_hold;
		@(posedge core_clk) disable iff (!arst_n)
		twoWire && clockPinDir && (st.startFlag || (st.wm[0] && st.ovfFlag)) |=>
			serialClockPinOe && !serialClockPinOut;
	endproperty
	a_clock_hold: assert property (p_clock_hold) else $error("clock line not held"); // R10 R14
endmodule : usu_serial_unit

// >>> common/usu_pkg.sv
package usu_pkg;
	localparam logic [11:0] ADDR_SHIFT = 12'h000;
	localparam logic [11:0] ADDR_BUFFER = 12'h004;
	localparam logic [11:0] ADDR_STATUS = 12'h008;
	localparam logic [11:0] ADDR_CONTROL = 12'h00C;
	// status word layout
	localparam int ST_START = 7;
	localparam int ST_OVF = 6;
	localparam int ST_STOP = 5;
	localparam int ST_COLL = 4;
	localparam int ST_CNT_LO = 0;
	// control word layout
	localparam int CT_SIE = 7;
	localparam int CT_OIE = 6;
	localparam int CT_WM_LO = 4;
	localparam int CT_CS_LO = 2;
	localparam int CT_SOFTCLK = 1;
	localparam int CT_TOGGLE = 0;
	localparam logic [7:0] SHIFT_RESET = 8'h00;
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam logic [3:0] CNT_MAX = 4'hF;
	localparam logic [3:0] CNT_STEP = 4'h1;
	typedef enum logic [1:0] {WM_NONE, WM_THREE, WM_TWO, WM_TWO_HOLD} usu_wire_t;
	typedef enum logic [1:0] {CS_SOFT, CS_TIMER, CS_EXT_RISE, CS_EXT_FALL} usu_clksel_t;
endpackage : usu_pkg

// >>> common/usu_pin_if.sv
`timescale 1ns/10ps
interface usu_pin_if;
	logic pin;
	logic level;
	logic rise;
	logic fall;
	modport sync (input pin, output level, output rise, output fall);
	modport user (output pin, input level, input rise, input fall);
endinterface : usu_pin_if

// >>> logic/usu_pin_sync.sv
`timescale 1ns/10ps
module usu_pin_sync (
	input wire logic core_clk, // system clock
	input wire logic arst_n, // async reset, active low
	usu_pin_if.sync pinIf // raw pin in, clean level and edges out
);
	typedef struct packed {
		logic stage1;
		logic stage2;
		logic prev;
		logic rise;
		logic fall;
	} usu_sync_t;

	usu_sync_t st;
	usu_sync_t next_st;

	always_comb
	begin
		next_st = st;
		next_st.stage1 = pinIf.pin;
		next_st.stage2 = st.stage1;
		next_st.prev = st.stage2;
		// edges compare the second stage with the third, never the first
		next_st.rise = st.stage2 & ~st.prev;
		next_st.fall = ~st.stage2 & st.prev;
	end

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			st <= '0;
		else
			st <= next_st;
	end

	assign pinIf.level = st.prev;
	assign pinIf.rise = st.rise;
	assign pinIf.fall = st.fall;
endmodule : usu_pin_sync

// >>> testbench/usu_link_partner.sv
`timescale 1ns/10ps
module usu_link_partner (
	output logic sclk, // serial clock made by the far side
	output logic mosi, // data toward the unit
	output logic sdaLow, // open-drain pull on the two-wire data line
	input wire logic miso // data from the unit
);
	// clock stands low outside frames; data rests on the inverse of its last bit
	initial
	begin
		sclk = 1'b0;
		mosi = 1'b0;
		sdaLow = 1'b0;
	end
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--)
		begin
			mosi = tx[i];
			#24 sclk = 1'b1;
			rx[i] = miso;
			#24 sclk = 1'b0;
		end
		mosi = ~mosi;
	endtask : xfer
	task automatic pulse();
		#24 sclk = 1'b1;
		#24 sclk = 1'b0;
	endtask : pulse
	task automatic line_event(input logic startNotStop);
		sdaLow = !startNotStop;
		#24 sclk = 1'b1;
		#24 sdaLow = startNotStop;
		#24 sclk = 1'b0;
		#24;
	endtask : line_event
	task automatic hold_sda(input logic v);
		sdaLow = v;
	endtask : hold_sda
endmodule : usu_link_partner

// >>> testbench/testbench.sv
`timescale 1ns/10ps
module testbench;
	localparam logic [11:0] A_SH = usu_pkg::ADDR_SHIFT;
	localparam logic [11:0] A_BF = usu_pkg::ADDR_BUFFER;
	localparam logic [11:0] A_ST = usu_pkg::ADDR_STATUS;
	localparam logic [11:0] A_CT = usu_pkg::ADDR_CONTROL;
	logic core_clk, arst_n, psel, penable, pwrite, pready, pslverr, globalIrqEnable, timerMatch, err;
	logic dataOutDir, clockPinDir, dataLineDir, serialDataIn, serialDataOut, serialDataOutOe;
	logic serialClockPinOut, serialClockPinOe, dataLineOut, dataLineOe, startIrq, overflowIrq;
	logic wakeAnySleep, wakeIdle, pClk, pSdaLow, clkWire, sdaWire;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [7:0] mShift, mBuf, tx, rx, got, ctl;
	logic [3:0] mCnt;
	logic mOvf;
	int mismatches, n_tests, seed;
	assign clkWire = serialClockPinOe ? serialClockPinOut : pClk;
	// pulled up when nobody pulls low
	assign sdaWire = dataLineOe ? dataLineOut : !pSdaLow;
	usu_serial_unit dut (.core_clk(core_clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.globalIrqEnable(globalIrqEnable), .timerMatch(timerMatch), .dataOutDir(dataOutDir),
		.clockPinDir(clockPinDir), .dataLineDir(dataLineDir), .serialDataIn(serialDataIn),
		.serialDataOut(serialDataOut), .serialDataOutOe(serialDataOutOe), .serialClockPinIn(clkWire),
		.serialClockPinOut(serialClockPinOut), .serialClockPinOe(serialClockPinOe), .dataLineIn(sdaWire),
		.dataLineOut(dataLineOut), .dataLineOe(dataLineOe), .startIrq(startIrq), .overflowIrq(overflowIrq),
		.wakeAnySleep(wakeAnySleep), .wakeIdle(wakeIdle));
	usu_link_partner p (.sclk(pClk), .mosi(serialDataIn), .sdaLow(pSdaLow), .miso(serialDataOut));
	initial
	begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : print_verdict
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e)
		begin
			mismatches++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d, input logic tm = 1'b0);
		int n;
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge core_clk);
		penable <= 1'b1;
		timerMatch <= tm;
		n = 0;
		do
		begin
			@(posedge core_clk);
			timerMatch <= 1'b0;
			n++;
		end
		while (pready !== 1'b1 && n < 16);
		if (n >= 16)
		begin
			mismatches++;
			print_verdict();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic mtick(input logic b);
		mShift = {mShift[6:0], b};
		mCnt = mCnt + 4'h1;
		if (mCnt === 4'h0)
		begin
			mOvf = 1'b1;
			mBuf = mShift;
		end
	endtask : mtick
	task automatic wt();
		repeat (6) @(posedge core_clk);
	endtask : wt
	initial
	begin
		#400000;
		mismatches++;
		print_verdict();
	end
	initial
	begin
		seed = 32'h8326;
		{psel, penable, pwrite, timerMatch, globalIrqEnable, dataOutDir, clockPinDir, dataLineDir} = '0;
		paddr = '0;
		pwdata = '0;
		{mShift, mBuf, mCnt, mOvf} = '0;
		arst_n = 1'b0;
		repeat (10) @(posedge core_clk);
		arst_n <= 1'b1;
		apb(0, A_ST, 8'h00);
		chk("status", 8'h00, rd);
		apb(0, A_CT, 8'h00);
		chk("control", 8'h00, rd);
		apb(0, 12'h010, 8'h00);
		chk("slverr", 1'b1, err);
		apb(1, A_CT, 8'h10);
		tx = 8'($random(seed));
		apb(1, A_SH, tx);
		mShift = tx;
		wt();
		chk("dataOut", tx[7], serialDataOut);
		for (int i = 0; i < 16; i++)
		begin
			apb(1, A_CT, 8'h12);
			mtick(serialDataIn);
			apb(0, A_ST, 8'h00);
			chk("status", {1'b0, mOvf, 2'b00, mCnt}, rd & 32'hEF);
			apb(0, A_SH, 8'h00);
			chk("shift", mShift, rd);
		end
		apb(0, A_BF, 8'h00);
		chk("buffer", mBuf, rd);
		apb(0, A_CT, 8'h00);
		chk("strobes", 8'h10, rd);
		globalIrqEnable <= 1'b1;
		apb(1, A_CT, 8'h50);
		wt();
		chk("ovfIrq", 1'b1, overflowIrq);
		chk("wakeIdle", 1'b1, wakeIdle);
		chk("wakeAny", 1'b0, wakeAnySleep);
		apb(1, A_ST, 8'h45);
		{mOvf, mCnt} = 5'h05;
		wt();
		chk("ovfIrq", 1'b0, overflowIrq);
		apb(1, A_CT, 8'h14);
		tx = 8'($random(seed));
		apb(1, A_SH, tx, 1'b1);
		apb(0, A_SH, 8'h00);
		chk("shiftWins", tx, rd);
		mShift = tx;
		apb(1, A_ST, 8'h0F);
		mCnt = 4'hF;
		timerMatch <= 1'b1;
		@(posedge core_clk);
		timerMatch <= 1'b0;
		mtick(serialDataIn);
		apb(0, A_ST, 8'h00);
		chk("status", {1'b0, mOvf, 2'b00, mCnt}, rd & 32'hEF);
		apb(0, A_SH, 8'h00);
		chk("shift", mShift, rd);
		apb(1, A_ST, 8'h40);
		dataOutDir <= 1'b1;
		for (int k = 0; k < 2; k++)
		begin
			ctl = k == 0 ? 8'h18 : 8'h08;
			apb(1, A_CT, ctl);
			tx = 8'($random(seed));
			rx = 8'($random(seed));
			apb(1, A_SH, tx);
			wt();
			chk("dataOutOe", ctl[4], serialDataOutOe);
			p.xfer(rx, got);
			wt();
			if (k == 0)
				chk("miso", tx, got);
			apb(0, A_SH, 8'h00);
			chk("shift", rx, rd);
			apb(0, A_BF, 8'h00);
			chk("buffer", rx, rd);
			apb(0, A_ST, 8'h00);
			chk("status", 8'h40, rd & 32'hEF);
			apb(1, A_ST, 8'h40);
		end
		dataOutDir <= 1'b0;
		apb(1, A_CT, 8'h90);
		p.pulse();
		wt();
		chk("startIrq", 1'b1, startIrq);
		chk("wakeAny", 1'b1, wakeAnySleep);
		apb(0, A_ST, 8'h00);
		chk("start", 8'h80, rd & 32'h80);
		apb(1, A_ST, 8'h80);
		wt();
		chk("startIrq", 1'b0, startIrq);
		dataLineDir <= 1'b1;
		apb(1, A_SH, 8'hFF);
		apb(1, A_CT, 8'h20);
		p.line_event(1'b1);
		wt();
		apb(0, A_ST, 8'h00);
		chk("start", 8'h80, rd & 32'h80);
		apb(1, A_ST, 8'h80);
		apb(1, A_CT, 8'hE0);
		p.line_event(1'b0);
		wt();
		apb(0, A_ST, 8'h00);
		chk("stop", 8'h20, rd & 32'hA0);
		chk("noIrq", 1'b0, startIrq | overflowIrq);
		apb(1, A_ST, 8'h20);
		apb(0, A_ST, 8'h00);
		chk("stop", 8'h00, rd & 32'h20);
		p.hold_sda(1'b1);
		apb(1, A_SH, 8'h80);
		wt();
		apb(0, A_ST, 8'h00);
		chk("collision", 8'h10, rd & 32'h10);
		apb(1, A_SH, 8'h00);
		wt();
		apb(0, A_ST, 8'h00);
		chk("collision", 8'h00, rd & 32'h10);
		p.hold_sda(1'b0);
		// two-wire clock hold by start and by overflow, then the toggle clock
		apb(1, A_SH, 8'hFF);
		clockPinDir <= 1'b1;
		apb(1, A_CT, 8'h21);
		wt();
		chk("sclOe", 1'b0, serialClockPinOe);
		p.line_event(1'b1);
		wt();
		chk("sclOe", 1'b1, serialClockPinOe);
		chk("sclOut", 1'b0, serialClockPinOut);
		apb(1, A_ST, 8'h80);
		wt();
		chk("sclOe", 1'b0, serialClockPinOe);
		apb(1, A_CT, 8'h30);
		apb(1, A_ST, 8'h0F);
		mShift = 8'hFF;
		mCnt = 4'hF;
		mtick(sdaWire);
		apb(1, A_CT, 8'h32);
		wt();
		chk("sclOe", 1'b1, serialClockPinOe);
		apb(0, A_BF, 8'h00);
		chk("buffer", mBuf, rd);
		apb(1, A_ST, 8'h40);
		wt();
		chk("sclOe", 1'b0, serialClockPinOe);
		apb(1, A_CT, 8'h0C);
		wt();
		apb(1, A_ST, 8'h00);
		apb(1, A_CT, 8'h0F);
		apb(1, A_CT, 8'h0F);
		apb(1, A_CT, 8'h0D);
		wt();
		apb(0, A_ST, 8'h00);
		chk("count", 8'h02, rd & 32'h0F);
		chk("sclOut", 1'b1, serialClockPinOut);
		print_verdict();
	end
endmodule : testbench
